// File: cbc_pkg.sv
// Package for the cell balancing controller.
// Holds offsets, fields, resets and timing counts.
package cbc_pkg;

    // ------------------------------------------------------------------
    // Register offsets on the plain register port
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_ONE   = 8'h00; // Duty setting.
    localparam logic [7:0] ADDR_CTRL_TWO   = 8'h01; // Go, auto, pause, abort, action.
    localparam logic [7:0] ADDR_DEVICE_CONFIGURATION   = 8'h02; // Neighbour forbid bit.
    localparam logic [7:0] ADDR_THERM_CONF = 8'h03; // Thermistor threshold and cool-off.
    localparam logic [7:0] ADDR_STOP_VOLT  = 8'h04; // Stop-voltage threshold.
    localparam logic [7:0] ADDR_STATE      = 8'h05; // Balancing state, read only.
    localparam logic [7:0] ADDR_TIMER_BASE = 8'h10; // First channel timer setting.

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CT2_GO      = 0; // Start command, self clearing.
    localparam int CT2_AUTO    = 1; // Automatic control select.
    localparam int CT2_PAUSE   = 2; // Host pause bit.
    localparam int CT2_FLTEN   = 3; // Fault abort enable.
    localparam int CT2_THEN    = 4; // Thermistor pause enable.
    localparam int CT2_ACT_LO  = 5; // Completion action, two bits.
    localparam int ST_RUN      = 0; // Balancing running.
    localparam int ST_DONE     = 1; // All channels finished.
    localparam int ST_BADCFG   = 2; // Bad configuration.
    localparam int ST_PAUSED   = 3; // Paused.
    localparam int ST_THERMAL  = 4; // Thermal pause seen.
    localparam int ST_ABORT    = 5; // Fault abort.

    // ------------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CTRL   = 8'h00;   // All control clear after reset.
    localparam logic [1:0] ACT_SHUTDN = 2'h2;    // Completion action code for shutdown.
    localparam int         MAX_ON     = 8;       // Most switches allowed in manual control.

    // ------------------------------------------------------------------
    // Timing: one timer tick and one duty slot, derived from ref_clk.
    // ------------------------------------------------------------------
    localparam int CLK_MHZ      = 250; // Clock rate.
    localparam int TICK_US      = 1000; // Timer tick length.
    localparam int TICK_CYC     = TICK_US * CLK_MHZ; // Cycles per tick.
    localparam int SLOT_US      = 100; // Duty slot length.
    localparam int SLOT_CYC     = SLOT_US * CLK_MHZ; // Cycles per duty slot.

endpackage : cbc_pkg

// File: cbc_controller.sv
// Cell balancing controller: switch control, configuration check, pause
// and resume, per-channel stop, abort and completion action.
// Assumes protector comparator results are synchronous.
//
// Overview of operation
// [R1] Manual: go turns on all non-zero timers.
// [R2] Host keeps manual switches at eight or fewer.
// [R3] Bad manual setup refuses start, sets flag.
// [R4] Auto single-parity: no alternation, duty ignored.
// [R5] Die over warning pauses, sets both flags.
// [R6] Die pause resumes below limit minus hysteresis.
// [R7] Thermistor over threshold pauses when enabled.
// [R8] Thermistor resumes below threshold plus cool-off.
// [R9] Pause freezes timers and settings.
// [R10] Host orders thermistor setup before go.
// [R11] Thermistor thresholds latch at protector restart.
// [R12] Channel stops on timer or low voltage.
// [R13] Host orders voltage-stop setup before go.
// [R14] Stop threshold latches at protector restart.
// [R15] Enabled unmasked fault aborts, sets flag.
// [R16] Balancing continues in sleep mode.
// [R17] Completion drives chosen power action.
// [R18] Host pause bit pauses anytime.
// [R19] Any pause turns switches off, sets flag.
// [R20] Fault during pause never aborts.
// [R21] Resume: only non-zero timers balance.
// [R22] Auto alternates odd and even groups.
// [R23] Per-channel timer expiry stops channel.
// [R24] Done only when all channels stopped.
// [R25] Paused flag clears on resume.
`timescale 1ns/10ps

module cbc_controller #(
    parameter int NCH      = 16,                  // Number of channels.
    parameter int TW       = 8,                   // Timer setting width.
    parameter int TICK_CYC = cbc_pkg::TICK_CYC,   // Cycles per timer tick.
    parameter int SLOT_CYC = cbc_pkg::SLOT_CYC    // Cycles per duty slot.
) (
    input  wire logic           ref_clk,          // Clock.
    input  wire logic           rst,              // Asynchronous reset, active high.
    input  wire logic [7:0]     reg_addr,         // Register address.
    input  wire logic [7:0]     reg_wdata,        // Write data.
    input  wire logic           reg_wr,           // Write strobe.
    input  wire logic           reg_rd,           // Read strobe.
    output logic      [7:0]     reg_rdata,        // Read data, one cycle later.
    input  wire logic [NCH-1:0] die_hot,          // Sensor above warning limit.
    input  wire logic [NCH-1:0] die_cool,         // Sensor below limit minus hysteresis.
    input  wire logic           therm_hot,        // Any thermistor above pause threshold.
    input  wire logic           therm_cool,       // All thermistors below recovery level.
    input  wire logic [NCH-1:0] cell_low,         // Channel below stop-voltage threshold.
    input  wire logic           fault_unmasked,   // Unmasked fault detected.
    input  wire logic           sleep_mode,       // Device in sleep mode.
    output logic      [NCH-1:0] balancing_switch, // Switch drive per channel.
    output logic                die_sense_en,     // Die sensors enabled.
    output logic      [3:0]     thermistor_pause_threshold, // To OT protector.
    output logic      [2:0]     cool_off_hysteresis,        // To OT protector.
    output logic      [7:0]     stop_voltage_threshold,     // To UV protector.
    output logic      [1:0]     power_action,     // Requested power mode.
    output logic                power_action_req  // Pulse on completion.
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [2:0]    odd_even_duty_q;               // Duty setting.
    logic          automatic_control_select_q;    // Auto control.
    logic          host_pause_bit_q;              // Host pause.
    logic          fault_abort_enable_q;          // Fault abort option.
    logic          thermistor_pause_enable_q;     // Thermistor pause option.
    logic [1:0]    completion_power_action_q;     // Completion action.
    logic          forbid_neighbour_switches_q;   // No-adjacent bit.

    logic [7:0]    therm_conf_q;                  // Threshold and cool-off.
    logic [7:0]    stop_volt_q;                   // Stop-voltage threshold.

    logic [TW-1:0] timer_set_q [NCH];             // Per-channel settings.
    logic [TW-1:0] timer_q     [NCH];             // Running countdowns.
    logic [NCH-1:0] chan_stop_q;                  // Channel stopped by voltage.

    logic          run_q;                         // Balancing running.
    logic          all_channels_finished_q;       // Completion flag.
    logic          bad_config_flag_q;             // Bad setup flag.
    logic          paused_flag_q;                 // Paused flag.
    logic          thermal_pause_flag_q;          // Thermal pause flag.
    logic          fault_abort_flag_q;            // Abort flag.

    logic          die_pause_q;                   // Die pause held.
    logic          therm_pause_q;                 // Thermistor pause held.

    logic          phase_q;                       // Zero for odd group.
    logic [31:0]   slot_cnt_q;                    // Duty slot counter.
    logic [31:0]   tick_cnt_q;                    // Timer tick counter.
    logic [7:0]    reg_rdata_q;                   // Read data register.

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire go_wr    = reg_wr && reg_addr == cbc_pkg::ADDR_CTRL_TWO
                    && reg_wdata[cbc_pkg::CT2_GO];           // Go command.
    wire paused   = die_pause_q || therm_pause_q || host_pause_bit_q; // Any cause.
    wire tick     = tick_cnt_q == 32'(TICK_CYC - 1);       // Timer tick.
    wire slot_end = slot_cnt_q == 32'(SLOT_CYC - 1);       // Duty slot end.

    // Per-channel enable and neighbour checks.
    logic [NCH-1:0] nz;                // Setting non-zero.
    logic [NCH-1:0] live;              // Channel still balancing.
    logic [NCH-1:0] adj2;              // Channel and next both enabled.
    logic [NCH-1:0] adj3;              // Three consecutive enabled.
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign nz[g]   = timer_set_q[g] != '0;
            assign live[g] = timer_q[g] != '0 && !chan_stop_q[g]; // see [R12] see [R23]
            if (g + 1 < NCH) begin : g_a2
                assign adj2[g] = nz[g] && nz[g+1];
            end else begin : g_n2
                assign adj2[g] = 1'b0;
            end
            if (g + 2 < NCH) begin : g_a3
                assign adj3[g] = nz[g] && nz[g+1] && nz[g+2];
            end else begin : g_n3
                assign adj3[g] = 1'b0;
            end
        end
    endgenerate

    // Population count of enabled channels.
    logic [5:0] n_on;                  // Enabled count.
    always_comb begin
        n_on = '0;
        for (int i = 0; i < NCH; i++) begin
            n_on = n_on + 6'(nz[i]);
        end
    end

    // Manual setups that must be refused at go.
    wire bad_cfg = !automatic_control_select_q &&
                   (n_on > 6'(cbc_pkg::MAX_ON) ||
                    (forbid_neighbour_switches_q && |adj2) ||
                    (!forbid_neighbour_switches_q && |adj3));   // see [R3]

    // Odd and even masks; channel 1 sits at bit 0 and is odd.
    logic [NCH-1:0] odd_mask;          // Odd-numbered channels.
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            odd_mask[i] = (i % 2) == 0;
        end
    end
    wire has_odd  = |(live & odd_mask);                   // Odd channels active.
    wire has_even = |(live & ~odd_mask);                  // Even channels active.
    wire alt      = automatic_control_select_q && has_odd && has_even; // see [R4]
    wire [NCH-1:0] grp = alt ? (phase_q ? ~odd_mask : odd_mask)
                             : {NCH{1'b1}};               // see [R1] see [R22]

    // Duty: odd group holds duty+1 slots of eight, even the rest.
    wire [3:0] odd_slots = {1'b0, odd_even_duty_q} + 4'h1;
    logic [2:0] slot_idx_q;            // Slot within an eight-slot frame.

    // Switches off while paused or stopped, otherwise by group.
    wire sw_next_on = run_q && !paused;                   // see [R19]
    wire all_done   = run_q && live == '0;                // see [R24]

    // ------------------------------------------------------------------
    // Register writes from software
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            odd_even_duty_q             <= '0;
            automatic_control_select_q  <= 1'b0;
            host_pause_bit_q            <= 1'b0;
            fault_abort_enable_q        <= 1'b0;
            thermistor_pause_enable_q   <= 1'b0;
            completion_power_action_q   <= '0;
            forbid_neighbour_switches_q <= 1'b0;
            therm_conf_q                <= cbc_pkg::RST_CTRL;
            stop_volt_q                 <= cbc_pkg::RST_CTRL;
            for (int i = 0; i < NCH; i++) begin
                timer_set_q[i] <= '0;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                cbc_pkg::ADDR_CTRL_ONE: begin
                    odd_even_duty_q <= reg_wdata[2:0];
                end
                cbc_pkg::ADDR_CTRL_TWO: begin
                    automatic_control_select_q <= reg_wdata[cbc_pkg::CT2_AUTO];
                    host_pause_bit_q           <= reg_wdata[cbc_pkg::CT2_PAUSE]; // see [R18]
                    fault_abort_enable_q       <= reg_wdata[cbc_pkg::CT2_FLTEN];
                    thermistor_pause_enable_q  <= reg_wdata[cbc_pkg::CT2_THEN];
                    completion_power_action_q  <= reg_wdata[cbc_pkg::CT2_ACT_LO +: 2];
                end
                cbc_pkg::ADDR_DEVICE_CONFIGURATION: begin
                    forbid_neighbour_switches_q <= reg_wdata[0];
                end
                cbc_pkg::ADDR_THERM_CONF: begin
                    therm_conf_q <= reg_wdata;  // Protector latches it on restart, see [R11]
                end
                cbc_pkg::ADDR_STOP_VOLT: begin
                    stop_volt_q <= reg_wdata;   // Protector latches it on restart, see [R14]
                end
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (reg_addr == cbc_pkg::ADDR_TIMER_BASE + 8'(i)) begin
                            timer_set_q[i] <= reg_wdata[TW-1:0];
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Run control, pause causes and flags
    // ------------------------------------------------------------------
    // Sleep mode is ignored: balancing runs on alone.
    // see [R16]
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_q                   <= 1'b0;
            all_channels_finished_q <= 1'b0;
            bad_config_flag_q       <= 1'b0;
            paused_flag_q           <= 1'b0;
            thermal_pause_flag_q    <= 1'b0;
            fault_abort_flag_q      <= 1'b0;
            die_pause_q             <= 1'b0;
            therm_pause_q           <= 1'b0;
            power_action_req        <= 1'b0;
        end else begin
            power_action_req <= 1'b0;
            if (go_wr) begin
                bad_config_flag_q       <= bad_cfg;
                all_channels_finished_q <= 1'b0;
                fault_abort_flag_q      <= 1'b0;
                thermal_pause_flag_q    <= 1'b0;
                run_q <= !bad_cfg && |nz;         // see [R3]
            end else if (run_q) begin
                // Die sensors over the warning limit, held until all cool.
                if (|die_hot) begin
                    die_pause_q <= 1'b1;          // see [R5]
                end else if (&die_cool) begin
                    die_pause_q <= 1'b0;          // see [R6]
                end

                if (thermistor_pause_enable_q && therm_hot) begin
                    therm_pause_q <= 1'b1;        // see [R7]
                end else if (therm_cool || !thermistor_pause_enable_q) begin
                    therm_pause_q <= 1'b0;        // see [R8]
                end

                if (|die_hot || (thermistor_pause_enable_q && therm_hot)) begin
                    thermal_pause_flag_q <= 1'b1;
                end

                paused_flag_q <= paused;          // see [R19] see [R25]

                if (fault_abort_enable_q && fault_unmasked && !paused) begin
                    run_q              <= 1'b0;   // see [R15] see [R20]
                    fault_abort_flag_q <= 1'b1;
                end else if (all_done) begin
                    run_q                   <= 1'b0;
                    all_channels_finished_q <= 1'b1; // see [R24]
                    power_action_req        <= 1'b1; // see [R17]
                end
            end else begin
                die_pause_q   <= 1'b0;
                therm_pause_q <= 1'b0;
                paused_flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Channel timers: load on go, count per tick, freeze in pause.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q  <= '0;
            chan_stop_q <= '0;
            for (int i = 0; i < NCH; i++) begin
                timer_q[i] <= '0;
            end
        end else if (go_wr) begin
            tick_cnt_q  <= '0;
            chan_stop_q <= '0;
            for (int i = 0; i < NCH; i++) begin
                timer_q[i] <= timer_set_q[i];
            end
        end else if (run_q && !paused) begin      // see [R9] see [R21]
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h1;

            for (int i = 0; i < NCH; i++) begin
                if (stop_volt_q != '0 && cell_low[i]) begin
                    chan_stop_q[i] <= 1'b1;       // see [R12]
                end

                if (tick && timer_q[i] != '0) begin
                    timer_q[i] <= timer_q[i] - TW'(1); // see [R23]
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Odd and even alternation, frozen while paused.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slot_cnt_q <= '0;
            slot_idx_q <= '0;
            phase_q    <= 1'b0;
        end else if (go_wr) begin
            slot_cnt_q <= '0;
            slot_idx_q <= '0;
            phase_q    <= 1'b0;
        end else if (run_q && !paused && slot_end) begin
            slot_cnt_q <= '0;
            slot_idx_q <= slot_idx_q + 3'h1;
            phase_q    <= {1'b0, slot_idx_q + 3'h1} >= odd_slots; // see [R22]
        end else if (run_q && !paused) begin
            slot_cnt_q <= slot_cnt_q + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // Outputs and read path
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            balancing_switch <= '0;
            power_action     <= '0;
            reg_rdata_q      <= '0;
        end else begin
            balancing_switch <= sw_next_on ? (live & grp) : '0; // see [R19] see [R21]
            if (all_done) begin
                power_action <= completion_power_action_q; // see [R17]
            end
            reg_rdata_q <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    cbc_pkg::ADDR_CTRL_ONE:   reg_rdata_q <= {5'h00, odd_even_duty_q};
                    cbc_pkg::ADDR_CTRL_TWO:   reg_rdata_q <= {1'b0, completion_power_action_q,
                                                thermistor_pause_enable_q, fault_abort_enable_q,
                                                host_pause_bit_q, automatic_control_select_q,
                                                1'b0};
                    cbc_pkg::ADDR_DEVICE_CONFIGURATION:   reg_rdata_q <= {7'h00, forbid_neighbour_switches_q};
                    cbc_pkg::ADDR_THERM_CONF: reg_rdata_q <= therm_conf_q;
                    cbc_pkg::ADDR_STOP_VOLT:  reg_rdata_q <= stop_volt_q;
                    cbc_pkg::ADDR_STATE:      reg_rdata_q <= {2'h0, fault_abort_flag_q,
                                                thermal_pause_flag_q, paused_flag_q,
                                                bad_config_flag_q, all_channels_finished_q,
                                                run_q};
                    default: begin
                        for (int i = 0; i < NCH; i++) begin
                            if (reg_addr == cbc_pkg::ADDR_TIMER_BASE + 8'(i)) begin
                                reg_rdata_q <= 8'(timer_set_q[i]);
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign reg_rdata                  = reg_rdata_q;

    assign die_sense_en               = run_q;   // Sensors on from go, see [R5]
    assign thermistor_pause_threshold = therm_conf_q[3:0];
    assign cool_off_hysteresis        = therm_conf_q[6:4];
    assign stop_voltage_threshold     = stop_volt_q;

endmodule : cbc_controller

// File: cbc_properties.sv
// Port checker bound onto cbc_controller.
// Assumes one clock and an active-high async reset.
`timescale 1ns/10ps
module cbc_properties #(parameter int NCH = 16) (
    input wire logic           ref_clk, rst, reg_wr, reg_rd,  // Clock, reset, strobes.
    input wire logic           fault_unmasked, die_sense_en,  // Fault and run level.
    input wire logic           power_action_req,              // Completion pulse.
    input wire logic [7:0]     reg_rdata, stop_voltage_threshold, // Byte outputs.
    input wire logic [NCH-1:0] die_hot, balancing_switch      // Per-channel levels.
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // A hot die sensor opens every switch two edges later.
    property p_hot; |die_hot |=> ##1 balancing_switch == '0; endproperty
    a_hot: assert property (p_hot) else $error("switch on while hot");
    property p_idle; !die_sense_en && !$past(die_sense_en) |-> balancing_switch == '0; endproperty
    a_idle: assert property (p_idle) else $error("switch on while idle");
    // A fault inside a held pause must not end the run.
    property p_pz; $past(|die_hot) && |die_hot && die_sense_en && fault_unmasked
        |=> die_sense_en; endproperty
    a_pz: assert property (p_pz) else $error("fault ended a paused run");
    property p_max; $countones(balancing_switch) <= cbc_pkg::MAX_ON; endproperty
    a_max: assert property (p_max) else $error("too many switches on");
    property p_rdz; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rdz: assert property (p_rdz) else $error("read data without read");
    property p_thr; !reg_wr |=> $stable(stop_voltage_threshold); endproperty
    a_thr: assert property (p_thr) else $error("stop level moved alone");
    property p_pulse; power_action_req |=> !power_action_req; endproperty
    a_pulse: assert property (p_pulse) else $error("action pulse too long");
    property p_done; power_action_req |=> !die_sense_en ##1 !die_sense_en; endproperty
    a_done: assert property (p_done) else $error("run after completion");
    c_hot: cover property (|die_hot && die_sense_en);
    c_done: cover property (power_action_req);
    c_fault: cover property (fault_unmasked && die_sense_en);
endmodule : cbc_properties

// File: cbc_sensor_model.sv
// Die sensor and thermistor protector model facing the controller.
// Assumes the bench drives heat and therm.
`timescale 1ns/10ps
module cbc_sensor_model (
    input  wire logic ref_clk, heat, therm, // Clock and bench events.
    output logic [15:0] die_hot = 16'h0000, die_cool = 16'hffff, // Die levels.
    output logic therm_hot = 1'h0, therm_cool = 1'h1 // Thermistor levels.
);
    // Cool lags hot by a cycle, like a real hysteresis gap.
    always @(posedge ref_clk) begin
        die_hot    <= {16{heat}};
        die_cool   <= ~die_hot & {16{~heat}};
        therm_hot  <= therm;
        therm_cool <= ~therm_hot & ~therm;
    end
endmodule : cbc_sensor_model

// File: cell_balance_controller_tb.sv
// Bench with short tick and slot counts.
// Assumes the sensor model and bound checker.
`timescale 1ns/10ps
module cell_balance_controller_tb;
    logic        ref_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0; // Clock, strobes.
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, svt; // Register port.
    logic        heat = 1'h0, therm = 1'h0, fault = 1'h0, sleep = 1'h0; // Bench events.
    logic [15:0] hot, cool, sw; // Sensors, switches.
    logic        th_hot, th_cool, dse, par; // Other outputs.
    logic [1:0]  pa; // Power action.
    int          miscompares = 0, checks = 0; // Counters.
    always #2 ref_clk = ~ref_clk;
    cbc_sensor_model cbc_sensor_model_i (.ref_clk, .heat, .therm, .die_hot(hot),
        .die_cool(cool), .therm_hot(th_hot), .therm_cool(th_cool));
    cbc_controller #(.TICK_CYC(4), .SLOT_CYC(2)) cbc_controller_i (.ref_clk, .rst,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .die_hot(hot), .die_cool(cool),
        .therm_hot(th_hot), .therm_cool(th_cool), .cell_low(16'h0000), .fault_unmasked(fault),
        .sleep_mode(sleep), .balancing_switch(sw), .die_sense_en(dse),
        .thermistor_pause_threshold(), .cool_off_hysteresis(), .stop_voltage_threshold(svt),
        .power_action(pa), .power_action_req(par));
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge ref_clk);
        reg_wr    <= 1'h0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge ref_clk);
        reg_rd   <= 1'h0;
        #1 chk({8'h00, reg_rdata}, {8'h00, e});
    endtask : rdc
    // Start a run, then check the state byte.
    task automatic go(input logic [7:0] d, input logic [7:0] st);
        wr(cbc_pkg::ADDR_CTRL_TWO, d);
        tick(2);
        rdc(cbc_pkg::ADDR_STATE, st);
    endtask : go
    task automatic print_verdict();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'h0;
        rdc(8'h7f, 8'h00);
        wr(cbc_pkg::ADDR_STOP_VOLT, 8'h5a);
        rdc(cbc_pkg::ADDR_STOP_VOLT, 8'h5a);
        chk({8'h00, svt}, 16'h005a);
        for (int i = 0; i < 3; i++) wr(cbc_pkg::ADDR_TIMER_BASE + 8'(i), 8'h20);
        go(8'h01, 8'h04);
        wr(cbc_pkg::ADDR_TIMER_BASE + 8'h02, 8'h00);
        wr(cbc_pkg::ADDR_DEVICE_CONFIGURATION, 8'h01);
        go(8'h01, 8'h04);
        wr(cbc_pkg::ADDR_DEVICE_CONFIGURATION, 8'h00);
        $display("test config done");
        go(8'h49, 8'h01);
        chk(sw, 16'h0003);
        @(posedge ref_clk) sleep <= 1'h1;
        @(posedge ref_clk) heat <= 1'h1;
        tick(3);
        chk(sw, 16'h0000);
        rdc(cbc_pkg::ADDR_STATE, 8'h19);
        @(posedge ref_clk) heat <= 1'h0;
        tick(5);
        chk(sw, 16'h0003);
        rdc(cbc_pkg::ADDR_STATE, 8'h11);
        wr(cbc_pkg::ADDR_CTRL_TWO, 8'h4c);
        @(posedge ref_clk) fault <= 1'h1;
        tick(2);
        chk(sw, 16'h0000);
        rdc(cbc_pkg::ADDR_STATE, 8'h19);
        @(posedge ref_clk) fault <= 1'h0;
        wr(cbc_pkg::ADDR_CTRL_TWO, 8'h48);
        for (int i = 0; i < 400 && par !== 1'h1; i++) tick(1);
        chk({14'h0000, pa}, {14'h0000, cbc_pkg::ACT_SHUTDN});
        rdc(cbc_pkg::ADDR_STATE, 8'h12);
        @(posedge ref_clk) sleep <= 1'h0;
        $display("test manual done");
        go(8'h09, 8'h01);
        @(posedge ref_clk) fault <= 1'h1;
        tick(3);
        rdc(cbc_pkg::ADDR_STATE, 8'h20);
        @(posedge ref_clk) fault <= 1'h0;
        wr(cbc_pkg::ADDR_TIMER_BASE + 8'h01, 8'h00);
        wr(cbc_pkg::ADDR_TIMER_BASE + 8'h02, 8'h20);
        wr(cbc_pkg::ADDR_THERM_CONF, 8'h35);
        go(8'h13, 8'h01);
        tick(6);
        chk(sw, 16'h0005);
        @(posedge ref_clk) therm <= 1'h1;
        tick(3);
        chk(sw, 16'h0000);
        @(posedge ref_clk) therm <= 1'h0;
        tick(5);
        chk(sw, 16'h0005);
        $display("test auto done");
        print_verdict();
    end
    // Tests take about 230 cycles; wide margin.
    initial begin
        #40000;
        miscompares++;
        print_verdict();
    end
endmodule : cell_balance_controller_tb
bind cbc_controller cbc_properties #(.NCH(NCH)) cbc_properties_i (.ref_clk, .rst, .reg_wr,
    .reg_rd, .fault_unmasked, .die_sense_en, .power_action_req, .reg_rdata,
    .stop_voltage_threshold, .die_hot, .balancing_switch);
